// [logic/keywake_lcd_regs.vh]
// opcode, width and reset constants for the wakeup/lcd transfer decoder
`ifndef KEYWAKE_LCD_REGS_VH
`define KEYWAKE_LCD_REGS_VH

`define OPC_WIDTH           10
`define ACC_WIDTH           4
`define OP_LOAD_WAKE_ZERO   10'h21b
`define OP_LOAD_WAKE_ONE    10'h214
`define OP_LOAD_WAKE_TWO    10'h215
`define OP_LOAD_LCD_ONE     10'h20a
`define OP_LOAD_LCD_TWO     10'h20b
`define SEL_WIDTH           5
`define SEL_WAKE_ZERO       0
`define SEL_WAKE_ONE        1
`define SEL_WAKE_TWO        2
`define SEL_LCD_ONE         3
`define SEL_LCD_TWO         4
`define CTRL_RESET          4'h0
`define INSTR_CYCLES        1

`endif

// [logic/transfer_op_decode.v]
// combinational opcode decoder for the five accumulator transfer ops
`timescale 1ns/1ps
`default_nettype none
`include "keywake_lcd_regs.vh"

module transfer_op_decode (
  input  wire [`OPC_WIDTH-1:0] i_opcode,
  input  wire                  i_valid,
  output reg  [`SEL_WIDTH-1:0] o_sel
);

  always @* begin
    o_sel = {`SEL_WIDTH{1'b0}};
    if (i_valid) begin
      case (i_opcode)
        `OP_LOAD_WAKE_ZERO: o_sel[`SEL_WAKE_ZERO] = 1'b1;
        `OP_LOAD_WAKE_ONE:  o_sel[`SEL_WAKE_ONE]  = 1'b1;
        `OP_LOAD_WAKE_TWO:  o_sel[`SEL_WAKE_TWO]  = 1'b1;
        `OP_LOAD_LCD_ONE:   o_sel[`SEL_LCD_ONE]   = 1'b1;
        `OP_LOAD_LCD_TWO:   o_sel[`SEL_LCD_TWO]   = 1'b1;
        default:            o_sel = {`SEL_WIDTH{1'b0}};
      endcase
    end
  end

endmodule // transfer_op_decode
`default_nettype wire

// [logic/keywake_lcd_reg_transfer_ops.v]
// accumulator-to-control-register transfer ops: wakeup and lcd registers
`timescale 1ns/1ps
`default_nettype none
`include "keywake_lcd_regs.vh"

module keywake_lcd_reg_transfer_ops #(
  parameter ACC_W = `ACC_WIDTH
) (
  input  wire                  i_clk_sys,
  input  wire                  i_srst,
  input  wire                  i_ce,
  input  wire                  i_instr_valid,
  input  wire [`OPC_WIDTH-1:0] i_opcode,
  input  wire [ACC_W-1:0]      i_acc,
  output reg  [ACC_W-1:0]      o_wakeup_ctrl_zero,
  output reg  [ACC_W-1:0]      o_wakeup_ctrl_one,
  output reg  [ACC_W-1:0]      o_wakeup_ctrl_two,
  output reg  [ACC_W-1:0]      o_lcd_ctrl_one,
  output reg  [ACC_W-1:0]      o_lcd_ctrl_two,
  output reg                   o_hit,
  output reg                   o_skip
);

  // ----------------------------------------------------------------
  // local constants
  // ----------------------------------------------------------------
  localparam SEL_W = `SEL_WIDTH;
  // every target leaves reset cleared, whatever width the core uses
  localparam [ACC_W-1:0] CTRL_INIT = {ACC_W{1'b0}};

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one target: the accumulator when selected, else the old value;
  // shared so the five targets cannot drift apart
  function [ACC_W-1:0] pick_value;
    input             take;
    input [ACC_W-1:0] acc;
    input [ACC_W-1:0] old;
    begin
      if (take)
        pick_value = acc;
      else
        pick_value = old;
    end
  endfunction

  // ----------------------------------------------------------------
  // reset and enable
  // ----------------------------------------------------------------
  // reset wins over the enable, so a core held in reset with its
  // enable low still comes up with every target cleared
  wire clear_all;
  wire advance;

  assign clear_all = i_srst;
  assign advance   = i_ce & ~i_srst;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // the decoder is purely combinational; every output below is still
  // taken from its own flop
  wire [SEL_W-1:0] sel;

  transfer_op_decode u_dec (
    .i_opcode (i_opcode),
    .i_valid  (i_instr_valid),
    .o_sel    (sel)
  );

  // ----------------------------------------------------------------
  // per-target strobes
  // ----------------------------------------------------------------
  wire take_wake_zero;
  wire take_wake_one;
  wire take_wake_two;
  wire take_lcd_one;
  wire take_lcd_two;
  wire take_any;

  assign take_wake_zero = sel[`SEL_WAKE_ZERO];
  assign take_wake_one  = sel[`SEL_WAKE_ONE];
  assign take_wake_two  = sel[`SEL_WAKE_TWO];
  assign take_lcd_one   = sel[`SEL_LCD_ONE];
  assign take_lcd_two   = sel[`SEL_LCD_TWO];
  assign take_any       = |sel;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  reg [ACC_W-1:0] next_wakeup_ctrl_zero;
  reg [ACC_W-1:0] next_wakeup_ctrl_one;
  reg [ACC_W-1:0] next_wakeup_ctrl_two;
  reg [ACC_W-1:0] next_lcd_ctrl_one;
  reg [ACC_W-1:0] next_lcd_ctrl_two;
  reg             next_hit;
  reg             next_skip;

  // the accumulator is only read here, never written, so carry and
  // accumulator cannot change through these ops
  always @* begin
    next_wakeup_ctrl_zero = pick_value(take_wake_zero, i_acc,
                                       o_wakeup_ctrl_zero);
    next_wakeup_ctrl_one  = pick_value(take_wake_one, i_acc,
                                       o_wakeup_ctrl_one);
    next_wakeup_ctrl_two  = pick_value(take_wake_two, i_acc,
                                       o_wakeup_ctrl_two);
    next_lcd_ctrl_one     = pick_value(take_lcd_one, i_acc,
                                       o_lcd_ctrl_one);
    next_lcd_ctrl_two     = pick_value(take_lcd_two, i_acc,
                                       o_lcd_ctrl_two);
    next_hit              = take_any;
    // no transfer op ever skips, so the skip request stays low
    next_skip             = 1'b0;
  end

  // ----------------------------------------------------------------
  // wakeup control zero
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (clear_all) begin
      o_wakeup_ctrl_zero <= CTRL_INIT;
    end else if (advance) begin
      o_wakeup_ctrl_zero <= next_wakeup_ctrl_zero;
    end else begin
      // low enable: state frozen
      o_wakeup_ctrl_zero <= o_wakeup_ctrl_zero;
    end
  end

  // ----------------------------------------------------------------
  // wakeup control one
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (clear_all) begin
      o_wakeup_ctrl_one <= CTRL_INIT;
    end else if (advance) begin
      o_wakeup_ctrl_one <= next_wakeup_ctrl_one;
    end else begin
      // low enable: state frozen
      o_wakeup_ctrl_one <= o_wakeup_ctrl_one;
    end
  end

  // ----------------------------------------------------------------
  // wakeup control two
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (clear_all) begin
      o_wakeup_ctrl_two <= CTRL_INIT;
    end else if (advance) begin
      o_wakeup_ctrl_two <= next_wakeup_ctrl_two;
    end else begin
      // low enable: state frozen
      o_wakeup_ctrl_two <= o_wakeup_ctrl_two;
    end
  end

  // ----------------------------------------------------------------
  // lcd control one
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (clear_all) begin
      o_lcd_ctrl_one <= CTRL_INIT;
    end else if (advance) begin
      o_lcd_ctrl_one <= next_lcd_ctrl_one;
    end else begin
      // low enable: state frozen
      o_lcd_ctrl_one <= o_lcd_ctrl_one;
    end
  end

  // ----------------------------------------------------------------
  // lcd control two
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (clear_all) begin
      o_lcd_ctrl_two <= CTRL_INIT;
    end else if (advance) begin
      o_lcd_ctrl_two <= next_lcd_ctrl_two;
    end else begin
      // low enable: state frozen
      o_lcd_ctrl_two <= o_lcd_ctrl_two;
    end
  end

  // ----------------------------------------------------------------
  // hit marker
  // ----------------------------------------------------------------
  // a low enable stretches the marker over the frozen cycles; the core
  // only looks at it on enabled edges, so one op still counts once
  always @(posedge i_clk_sys) begin
    if (clear_all) begin
      o_hit <= 1'b0;
    end else if (advance) begin
      o_hit <= next_hit;
    end else begin
      // low enable: state frozen
      o_hit <= o_hit;
    end
  end

  // ----------------------------------------------------------------
  // skip request
  // ----------------------------------------------------------------
  // kept as a flop so the sequencer sees the same timing as other ops
  always @(posedge i_clk_sys) begin
    if (clear_all) begin
      o_skip <= 1'b0;
    end else if (advance) begin
      o_skip <= next_skip;
    end else begin
      // low enable: state frozen
      o_skip <= o_skip;
    end
  end

endmodule // keywake_lcd_reg_transfer_ops
`default_nettype wire

// [tb/xfer_chk_assertions.sv]
// assertion checker for the wakeup/lcd transfer decoder
`timescale 1ns/1ps
`default_nettype none
module xfer_chk (
  input wire       i_clk_sys,
  input wire       i_srst,
  input wire       i_ce,
  input wire       i_instr_valid,
  input wire [9:0] i_opcode,
  input wire [3:0] i_acc,
  input wire [3:0] o_wakeup_ctrl_zero,
  input wire [3:0] o_wakeup_ctrl_one,
  input wire [3:0] o_wakeup_ctrl_two,
  input wire [3:0] o_lcd_ctrl_one,
  input wire [3:0] o_lcd_ctrl_two,
  input wire       o_hit,
  input wire       o_skip
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // the five transfer codes, spelled out apart from the decoder
  wire        is_xfer  = i_opcode == 10'h21b || i_opcode == 10'h214 ||
                         i_opcode == 10'h215 || i_opcode == 10'h20a ||
                         i_opcode == 10'h20b;
  wire [19:0] ctrl_all = {o_lcd_ctrl_two, o_lcd_ctrl_one,
                          o_wakeup_ctrl_two, o_wakeup_ctrl_one,
                          o_wakeup_ctrl_zero};
  // a refused word or a low valid leaves every target alone, no hit
  property miss_quiet;
    i_ce && !(i_instr_valid && is_xfer) |=> !o_hit && $stable(ctrl_all);
  endproperty
  // a low enable freezes every output of the block
  property ce_frozen;
    !i_ce |=> $stable(ctrl_all) && $stable(o_hit) && $stable(o_skip);
  endproperty
  // the target must hold the old accumulator and the hit must show together
  property ld(op, r);
    i_ce && i_instr_valid && i_opcode == op |=> r == $past(i_acc) && o_hit;
  endproperty
  chk_ld_w0: assert property (ld(10'h21b, o_wakeup_ctrl_zero))
    else $error("w0 bad");
  chk_ld_w1: assert property (ld(10'h214, o_wakeup_ctrl_one))
    else $error("w1 bad");
  chk_ld_w2: assert property (ld(10'h215, o_wakeup_ctrl_two))
    else $error("w2 bad");
  chk_ld_l1: assert property (ld(10'h20a, o_lcd_ctrl_one))
    else $error("l1 bad");
  chk_ld_l2: assert property (ld(10'h20b, o_lcd_ctrl_two))
    else $error("l2 bad");
  chk_no_skip: assert property (!o_skip) else $error("skip");
  chk_miss_quiet: assert property (miss_quiet)
    else $error("refused op changed state");
  chk_ce_freeze: assert property (ce_frozen)
    else $error("state moved with enable low");
  cover property (o_hit ##1 o_hit);
  cover property (!i_ce && i_instr_valid);
  cover property ($fell(i_srst));
endmodule // xfer_chk
bind keywake_lcd_reg_transfer_ops xfer_chk u_chk (.*);
`default_nettype wire

// [tb/keywake_lcd_reg_transfer_ops_bench.sv]
// self-checking bench for the transfer decoder
`timescale 1ns/1ps
`default_nettype none
`define CK(x, y) n_compared++; if ((x) !== (y)) begin fails++; \
  $display("[FAIL] %0t bad", $time); end
module keywake_lcd_reg_transfer_ops_bench;
  logic            c = 0, r = 1, e = 1, v = 1, h, s;
  logic [9:0]      o = 10'h000;
  logic [3:0]      a = 4'h0;
  logic [4:0][3:0] q;
  logic [4:0][9:0] t = {10'h20b, 10'h20a, 10'h215, 10'h214, 10'h21b};
  int              fails = 0, n_compared = 0;
  keywake_lcd_reg_transfer_ops u_dut (.i_clk_sys(c), .i_srst(r), .i_ce(e),
    .i_instr_valid(v), .i_opcode(o), .i_acc(a), .o_hit(h), .o_skip(s),
    .o_wakeup_ctrl_zero(q[0]), .o_wakeup_ctrl_one(q[1]),
    .o_wakeup_ctrl_two(q[2]), .o_lcd_ctrl_one(q[3]), .o_lcd_ctrl_two(q[4]));
  initial forever #12.5 c = ~c;
  task op(input [9:0] p, input [3:0] d, input x);
    @(negedge c) {o, a} = {p, d};
    @(negedge c) `CK({h, s}, {x, 1'b0})
  endtask
  task loads; // all five transfers back to back
    for (int i = 0; i < 5; i++) op(t[i], 4'h5 + 4'(i), 1'b1);
    `CK(q, 20'h98765)
  endtask
  task refuse; // a near-miss opcode, then a frozen enable, then reset
    op(10'h21c, 4'hf, 1'b0);
    e = 0;
    op(10'h21b, 4'hf, 1'b0);
    `CK(q, 20'h98765)
    r = 1;
    @(negedge c) `CK({q, h}, 21'h0)
  endtask
  task quiet; // a transfer code with valid low must not load or hit
    v = 0;
    op(10'h214, 4'h3, 1'b0);
    `CK(q, 20'h98765)
    {v, o} = {1'b1, 10'h000};
  endtask
  task restart; // mid-run release: quiet first edges, then a normal load
    {e, o} = {1'b1, 10'h000};
    @(negedge c) r = 0;
    @(negedge c) `CK({q, h, s}, 22'h0)
    op(10'h20a, 4'hc, 1'b1);
    `CK(q, 20'h0c000)
  endtask
  task conclude;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge c);
    r = 0;
    loads;
    quiet;
    refuse;
    restart;
    conclude;
  end
endmodule // keywake_lcd_reg_transfer_ops_bench
`default_nettype wire
